// [design/tcc_params.svh]
/*
 * Register map, reset values and field positions of the capture/compare and PWM register set.
 * Assumes word addressing on the register bus (one 32-bit word per register).
 */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_ADDR_W        6
`define TCC_A_CAPCMP      6'h00
`define TCC_N_CAPCMP      6'h0C
`define TCC_A_EVCMP       6'h0C
`define TCC_N_EVCMP       6'h06
`define TCC_A_MATCH11     6'h12
`define TCC_N_MATCH11     6'h02
`define TCC_A_OSB         6'h14
`define TCC_N_OSB         6'h02
`define TCC_A_PERIOD      6'h18
`define TCC_N_PWM         6'h08
`define TCC_A_SHADOW      6'h20
`define TCC_A_DUTY        6'h28
`define TCC_A_STATUS      6'h30
`define TCC_A_MASK        6'h31

`define TCC_RST_W16       16'hFFFF
`define TCC_RST_W8        8'hFF
`define TCC_RST_OSB       16'h0000

`define TCC_FLAGS_W       28
`define TCC_FLG_CAPCMP    0
`define TCC_FLG_MATCH11   12
`define TCC_FLG_EVCMP     14
`define TCC_FLG_PERIOD    20

`endif

// [design/tcc_pkg.sv]
/*
 * Types shared by the capture/compare and PWM register set.
 * Assumes tcc_params.svh carries every number.
 */
`default_nettype none

package tcc_pkg;

    // Pin function of one capture/compare register.
    // Capture: sel bit0 rising edge, bit1 falling edge.
    // Compare: 00 no change, 01 drive low, 10 drive high, 11 toggle.
    typedef struct packed {
        logic       is_capture;
        logic [1:0] sel;
    } tcc_pfs_type;

endpackage : tcc_pkg

`default_nettype wire

// [design/tcc_regs.sv]
/*
 * Capture/compare, event compare, compare match, offset-base capture and PWM period/duty registers
 * of a multi-channel timer, with an Avalon-MM slave, sticky flags, mask and one interrupt line.
 * Assumes free counts, event tallies and pin-function settings come from counter logic on clk_sys,
 * capture pins are asynchronous, and standby is a level on clk_sys.
 */
// Added by the designer: the register addresses and the Avalon-MM register port.
//
// Overview of operation
// - Capture mode latches free count, sets flag
// - Pin function picks capture/compare and edge
// - Channel 9 match captures channel 3, no flag
// - Compare equality sets flag, drives output action
// - Capture/compare regs word-only, reset to ones
// - Event compare match flags on next edge
// - Trigger enable gates channel 9 capture trigger
// - Event compare regs byte access, reset ones
// - Channel 11 equality sets flag, output action
// - Channel 11 A/B matches go to sequencer
// - Offset-base regs latch on channel 0 edge
// - Offset-base regs read-only, reset to zero
// - Period match: flag, clear counter, load duty
// - Period regs word-only, reset to ones
// - Duty match drives PWM pin low
// - Shadow duty regs word-only, reset ones
// - Duty regs word-only, reset to ones
`include "tcc_params.svh"
`default_nettype none

module tcc_regs
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  standby,
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output var  logic [31:0]           avs_readdata,
    output var  logic                  avs_waitrequest,
    output var  logic                  irq,
    input  wire logic [11:0]           cc_pin,
    input  wire tcc_pfs_type [11:0]    cc_pfs,
    input  wire logic [2:0][15:0]      cc_free_count,
    output var  logic [11:0]           cc_cmp_out,
    input  wire logic [5:0][7:0]       ch9_tally,
    input  wire logic [5:0]            ch9_edge,
    input  wire logic [3:0]            ch3_trigger_enable,
    output var  logic [5:0]            ch9_match,
    input  wire logic [15:0]           ch11_free_count,
    input  wire tcc_pfs_type [1:0]     ch11_pfs,
    output var  logic [1:0]            ch11_cmp_out,
    output var  logic [1:0]            pulse_sequencer_trig,
    input  wire logic                  chan0_capture_a,
    input  wire logic [1:0]            osb_edge_sel,
    input  wire logic [15:0]           ch1_free_count,
    input  wire logic [15:0]           ch2_free_count,
    input  wire logic [7:0][15:0]      pwm_free_count,
    output var  logic [7:0]            pwm_count_clear,
    output var  logic [7:0]            pwm_out_pin
);

    if (CNT_W != 16) begin : g_bad_width
        $error("tcc_regs: register map serves 16-bit counts only");
    end

    function automatic logic cap_edge(input logic [1:0] sel, input logic rise, input logic fall);
        cap_edge = (sel[0] & rise) | (sel[1] & fall);
    endfunction : cap_edge

    function automatic logic cmp_action(input logic [1:0] sel, input logic cur);
        case (sel)
            2'h1:    cmp_action = 1'b0;
            2'h2:    cmp_action = 1'b1;
            2'h3:    cmp_action = ~cur;
            default: cmp_action = cur;
        endcase
    endfunction : cmp_action

    function automatic logic in_rng(input logic [5:0] a, input logic [5:0] base, input logic [5:0] n);
        in_rng = (a >= base) && (a < 6'(base + n));
    endfunction : in_rng

    // Storage
    logic [15:0]              cc_r        [12];
    logic [15:0]              cc_nxt      [12];
    logic [7:0]               ev_r        [6];
    logic [7:0]               ev_nxt      [6];
    logic [15:0]              m11_r       [2];
    logic [15:0]              m11_nxt     [2];
    logic [15:0]              osb_r       [2];
    logic [15:0]              osb_nxt     [2];
    logic [15:0]              per_r       [8];
    logic [15:0]              per_nxt     [8];
    logic [15:0]              shd_r       [8];
    logic [15:0]              shd_nxt     [8];
    logic [15:0]              dty_r       [8];
    logic [15:0]              dty_nxt     [8];
    logic [`TCC_FLAGS_W-1:0]  status_r;
    logic [`TCC_FLAGS_W-1:0]  status_nxt;
    logic [`TCC_FLAGS_W-1:0]  mask_r;
    logic [29:0]              eq_prev_r;
    logic [11:0]              cc_out_nxt;
    logic [1:0]               m11_out_nxt;
    logic [7:0]               pwm_nxt;
    logic                     ack_r;
    logic [31:0]              rd_nxt;

    // Pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edge detection
    logic [12:0] pin_s1_r;
    logic [12:0] pin_s2_r;
    logic [12:0] pin_s3_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 13'h0000;
            pin_s2_r <= 13'h0000;
            pin_s3_r <= 13'h0000;
        end else begin
            pin_s1_r <= {chan0_capture_a, cc_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    wire [12:0] pin_rise = pin_s2_r & ~pin_s3_r;
    wire [12:0] pin_fall = ~pin_s2_r & pin_s3_r;

    // Compare equalities; only the first cycle of equality counts, so a stalled counter fires once
    wire [29:0] eq_now;
    wire [29:0] eq_evt = eq_now & ~eq_prev_r;
    wire [5:0]  ch9_eq;
    wire [5:0]  ch9_hit;
    wire [11:0] cc_pin_cap;
    wire [11:0] cc_trig_cap;
    wire [11:0] cc_cap;
    wire [11:0] cc_flag_set;
    wire [7:0]  per_evt = eq_evt[21:14];
    wire [7:0]  dty_evt = eq_evt[29:22];
    wire        osb_hit = cap_edge(osb_edge_sel, pin_rise[12], pin_fall[12]);

    for (genvar i = 0; i < 12; i++) begin : g_cc
        assign eq_now[i]      = cc_r[i] == cc_free_count[i/4];
        assign cc_pin_cap[i]  = cc_pfs[i].is_capture & cap_edge(cc_pfs[i].sel, pin_rise[i], pin_fall[i]);
        if (i < 4) begin : g_trig
            assign cc_trig_cap[i] = cc_pfs[i].is_capture & ch3_trigger_enable[i] & ch9_hit[i];
        end else begin : g_notrig
            assign cc_trig_cap[i] = 1'b0;
        end
        assign cc_cap[i]      = cc_pin_cap[i] | cc_trig_cap[i];
        // Trigger-only captures leave the flag alone
        assign cc_flag_set[i] = cc_pin_cap[i] | (~cc_pfs[i].is_capture & eq_evt[i]);
    end

    for (genvar k = 0; k < 6; k++) begin : g_ev
        assign ch9_eq[k]  = ev_r[k] == ch9_tally[k];
        assign ch9_hit[k] = ch9_eq[k] & ch9_edge[k];
    end

    for (genvar j = 0; j < 2; j++) begin : g_m11
        assign eq_now[12+j] = m11_r[j] == ch11_free_count;
    end

    for (genvar j = 0; j < 8; j++) begin : g_pwm
        assign eq_now[14+j] = per_r[j] == pwm_free_count[j];
        assign eq_now[22+j] = dty_r[j] == pwm_free_count[j];
    end

    // Avalon slave: one wait state on every access
    wire        bus_req  = avs_read | avs_write;
    wire        wr_go    = avs_write & ack_r;
    wire        be_word  = avs_byteenable[1:0] == 2'h3;
    wire        wr16     = wr_go & be_word;
    wire        wr8      = wr_go & avs_byteenable[0];
    wire [15:0] wd16     = avs_writedata[15:0];
    wire [5:0]  a        = avs_address;
    wire        sel_cc   = in_rng(a, `TCC_A_CAPCMP, `TCC_N_CAPCMP);
    wire        sel_ev   = in_rng(a, `TCC_A_EVCMP, `TCC_N_EVCMP);
    wire        sel_m11  = in_rng(a, `TCC_A_MATCH11, `TCC_N_MATCH11);
    wire        sel_osb  = in_rng(a, `TCC_A_OSB, `TCC_N_OSB);
    wire        sel_per  = in_rng(a, `TCC_A_PERIOD, `TCC_N_PWM);
    wire        sel_shd  = in_rng(a, `TCC_A_SHADOW, `TCC_N_PWM);
    wire        sel_dty  = in_rng(a, `TCC_A_DUTY, `TCC_N_PWM);
    wire        sel_stat = a == `TCC_A_STATUS;
    wire        sel_mask = a == `TCC_A_MASK;
    wire [5:0]  off_cc   = 6'(a - `TCC_A_CAPCMP);
    wire [5:0]  off_ev   = 6'(a - `TCC_A_EVCMP);
    wire [5:0]  off_m11  = 6'(a - `TCC_A_MATCH11);
    wire [5:0]  off_osb  = 6'(a - `TCC_A_OSB);
    wire [5:0]  off_per  = 6'(a - `TCC_A_PERIOD);
    wire [5:0]  off_shd  = 6'(a - `TCC_A_SHADOW);
    wire [5:0]  off_dty  = 6'(a - `TCC_A_DUTY);

    wire [`TCC_FLAGS_W-1:0] flag_set = {per_evt, ch9_hit, eq_evt[13:12], cc_flag_set};
    wire [`TCC_FLAGS_W-1:0] flag_clr = (wr_go && sel_stat) ? avs_writedata[`TCC_FLAGS_W-1:0] : '0;

    assign avs_waitrequest = bus_req & ~ack_r;
    assign irq             = |(status_r & mask_r);
    // Hardware set wins over a write-one-to-clear in the same cycle
    assign status_nxt      = (status_r & ~flag_clr) | flag_set;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (sel_cc) begin
            rd_nxt[15:0] = cc_r[off_cc[3:0]];
        end else if (sel_ev) begin
            rd_nxt[7:0] = ev_r[off_ev[2:0]];
        end else if (sel_m11) begin
            rd_nxt[15:0] = m11_r[off_m11[0]];
        end else if (sel_osb) begin
            rd_nxt[15:0] = osb_r[off_osb[0]];
        end else if (sel_per) begin
            rd_nxt[15:0] = per_r[off_per[2:0]];
        end else if (sel_shd) begin
            rd_nxt[15:0] = shd_r[off_shd[2:0]];
        end else if (sel_dty) begin
            rd_nxt[15:0] = dty_r[off_dty[2:0]];
        end else if (sel_stat) begin
            rd_nxt[`TCC_FLAGS_W-1:0] = status_r;
        end else if (sel_mask) begin
            rd_nxt[`TCC_FLAGS_W-1:0] = mask_r;
        end
    end

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            cc_nxt[i]     = cc_r[i];
            cc_out_nxt[i] = cc_cmp_out[i];
            if (wr16 && sel_cc && off_cc == 6'(i)) begin
                cc_nxt[i] = wd16;
            end
            if (cc_cap[i]) begin
                cc_nxt[i] = cc_free_count[i/4];
            end
            if (!cc_pfs[i].is_capture && eq_evt[i]) begin
                cc_out_nxt[i] = cmp_action(cc_pfs[i].sel, cc_cmp_out[i]);
            end
        end
        for (int k = 0; k < 6; k++) begin
            ev_nxt[k] = (wr8 && sel_ev && off_ev == 6'(k)) ? avs_writedata[7:0] : ev_r[k];
        end
        for (int j = 0; j < 2; j++) begin
            m11_nxt[j]     = (wr16 && sel_m11 && off_m11 == 6'(j)) ? wd16 : m11_r[j];
            m11_out_nxt[j] = eq_evt[12+j] ? cmp_action(ch11_pfs[j].sel, ch11_cmp_out[j]) : ch11_cmp_out[j];
        end
        // Offset-base registers have no write path
        osb_nxt[0] = osb_hit ? ch1_free_count : osb_r[0];
        osb_nxt[1] = osb_hit ? ch2_free_count : osb_r[1];
        for (int j = 0; j < 8; j++) begin
            per_nxt[j] = (wr16 && sel_per && off_per == 6'(j)) ? wd16 : per_r[j];
            shd_nxt[j] = (wr16 && sel_shd && off_shd == 6'(j)) ? wd16 : shd_r[j];
            dty_nxt[j] = (wr16 && sel_dty && off_dty == 6'(j)) ? wd16 : dty_r[j];
            if (per_evt[j]) begin
                dty_nxt[j] = shd_r[j];
            end
            // Period match wins so a duty equal to the period gives a full-high output
            if (per_evt[j]) begin
                pwm_nxt[j] = 1'b1;
            end else if (dty_evt[j]) begin
                pwm_nxt[j] = 1'b0;
            end else begin
                pwm_nxt[j] = pwm_out_pin[j];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (avs_read && !ack_r) begin
                avs_readdata <= rd_nxt;
            end
        end
    end

    // Standby acts like power-on reset on every register but the bus handshake, read data and pin synchronisers; synchronous, so only rst_n is asynchronous
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 12; i++) cc_r[i] <= `TCC_RST_W16;
            for (int k = 0; k < 6; k++)  ev_r[k] <= `TCC_RST_W8;
            for (int j = 0; j < 2; j++)  m11_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 2; j++)  osb_r[j] <= `TCC_RST_OSB;
            for (int j = 0; j < 8; j++)  per_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 8; j++)  shd_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 8; j++)  dty_r[j] <= `TCC_RST_W16;
            status_r             <= '0;
            mask_r               <= '0;
            eq_prev_r            <= 30'h0000_0000;
            cc_cmp_out           <= 12'h000;
            ch11_cmp_out         <= 2'h0;
            ch9_match            <= 6'h00;
            pulse_sequencer_trig <= 2'h0;
            pwm_count_clear      <= 8'h00;
            pwm_out_pin          <= 8'h00;
        end else if (standby) begin
            for (int i = 0; i < 12; i++) cc_r[i] <= `TCC_RST_W16;
            for (int k = 0; k < 6; k++)  ev_r[k] <= `TCC_RST_W8;
            for (int j = 0; j < 2; j++)  m11_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 2; j++)  osb_r[j] <= `TCC_RST_OSB;
            for (int j = 0; j < 8; j++)  per_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 8; j++)  shd_r[j] <= `TCC_RST_W16;
            for (int j = 0; j < 8; j++)  dty_r[j] <= `TCC_RST_W16;
            status_r             <= '0;
            mask_r               <= '0;
            eq_prev_r            <= 30'h0000_0000;
            cc_cmp_out           <= 12'h000;
            ch11_cmp_out         <= 2'h0;
            ch9_match            <= 6'h00;
            pulse_sequencer_trig <= 2'h0;
            pwm_count_clear      <= 8'h00;
            pwm_out_pin          <= 8'h00;
        end else begin
            cc_r                 <= cc_nxt;
            ev_r                 <= ev_nxt;
            m11_r                <= m11_nxt;
            osb_r                <= osb_nxt;
            per_r                <= per_nxt;
            shd_r                <= shd_nxt;
            dty_r                <= dty_nxt;
            status_r             <= status_nxt;
            if (wr_go && sel_mask) mask_r <= avs_writedata[`TCC_FLAGS_W-1:0];
            eq_prev_r            <= eq_now;
            cc_cmp_out           <= cc_out_nxt;
            ch11_cmp_out         <= m11_out_nxt;
            ch9_match            <= ch9_eq;
            pulse_sequencer_trig <= eq_evt[13:12];
            pwm_count_clear      <= per_evt;
            pwm_out_pin          <= pwm_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_capture_value: assert property (cc_pin_cap[0] && !standby |=> cc_r[0] == $past(cc_free_count[0]))
        else $error("capture did not store free count");
    a_capture_flag: assert property (cc_pin_cap[0] && !standby |=> status_r[0])
        else $error("capture flag not set");
    a_trigger_noflag: assert property (cc_trig_cap[0] && !cc_pin_cap[0] && !status_r[0] && !standby
        |=> !status_r[0] && cc_r[0] == $past(cc_free_count[0]))
        else $error("channel 9 triggered capture wrong");
    a_compare_high: assert property (eq_evt[1] && !cc_pfs[1].is_capture && cc_pfs[1].sel == 2'h2
        && !standby |=> cc_cmp_out[1] && status_r[1])
        else $error("compare output action missing");
    a_word_only: assert property (wr_go && sel_shd && off_shd == 6'h03 && !be_word && !standby
        |=> $stable(shd_r[3]))
        else $error("narrow write changed shadow duty register");
    a_standby_ones: assert property (standby |=> cc_r[0] == `TCC_RST_W16 && ev_r[0] == `TCC_RST_W8
        && osb_r[0] == `TCC_RST_OSB && dty_r[7] == `TCC_RST_W16)
        else $error("standby did not reset registers");
    a_ev_flag_edge: assert property (ch9_edge[0] && ev_r[0] == ch9_tally[0] && !standby
        |=> status_r[`TCC_FLG_EVCMP])
        else $error("event compare flag not set on edge");
    a_seq_forward: assert property (eq_evt[12] && !standby |=> pulse_sequencer_trig[0] ##1 !pulse_sequencer_trig[0])
        else $error("match pulse not forwarded once");
    a_osb_latch: assert property (osb_hit && !standby |=> osb_r[1] == $past(ch2_free_count))
        else $error("offset base not latched");
    a_period_load: assert property (per_evt[0] && !standby
        |=> dty_r[0] == $past(shd_r[0]) && pwm_count_clear[0] && pwm_out_pin[0] && status_r[`TCC_FLG_PERIOD])
        else $error("period match actions missing");
    a_duty_low: assert property (dty_evt[0] && !per_evt[0] && !standby |=> !pwm_out_pin[0])
        else $error("duty match did not drive pin low");
    a_irq_level: assert property ((flag_set & mask_r) != '0 && !(wr_go && sel_mask) && !standby |=> irq)
        else $error("interrupt not raised");

    c_pin_capture: cover property (cc_pin_cap[0] && !standby);
    c_trigger_capture: cover property (cc_trig_cap[0] && !standby);
    c_pwm_cycle: cover property (per_evt[0] ##[1:200] dty_evt[0]);

endmodule : tcc_regs

`default_nettype wire

// [bench/tcc_far_side.sv]
/* Far-side model: capture pins and the PWM free counts.
   Assumes the block's clk_sys and rst_n. */
`default_nettype none
module tcc_far_side (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [7:0]       pwm_count_clear,
    output var  logic [7:0][15:0] pwm_free_count,
    output var  logic [11:0]      cc_pin,
    output var  logic             chan0_capture_a
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counters run free and restart on the clear request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwm_free_count <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pwm_free_count[i] <= pwm_count_clear[i] ? 16'h0 : pwm_free_count[i] + 16'h1;
            end
        end
    end
    // Pin levels move only after an edge; index 12 is the channel 0 pin
    task automatic edge_pin(input int idx, input logic lvl);
        @(posedge clk_sys);
        if (idx < 12) cc_pin[idx] <= lvl;
        else chan0_capture_a <= lvl;
    endtask : edge_pin
    initial begin
        cc_pin = '0;
        chan0_capture_a = 1'h0;
    end
endmodule : tcc_far_side
`default_nettype wire

// [bench/tcc_regs_tb_top.sv]
/* Self-checking bench for tcc_regs: registers, captures, compares, PWM.
   Assumes tcc_far_side supplies the pins and PWM counts. */
`default_nettype none
module tcc_regs_tb_top
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_sys, rst_n, standby, avs_read, avs_write, avs_waitrequest, irq, chan0_capture_a;
    logic [5:0]         avs_address, ch9_edge, ch9_match;
    logic [31:0]        avs_writedata, avs_readdata, rd, seed;
    logic [3:0]         avs_byteenable, ch3_trigger_enable;
    logic [11:0]        cc_pin, cc_cmp_out;
    tcc_pfs_type [11:0] cc_pfs;
    tcc_pfs_type [1:0]  ch11_pfs;
    logic [2:0][15:0]   cc_free_count;
    logic [5:0][7:0]    ch9_tally;
    logic [1:0]         ch11_cmp_out, pulse_sequencer_trig, osb_edge_sel;
    logic [15:0]        ch11_free_count, ch1_free_count, ch2_free_count, v, c, p, d, e;
    logic [7:0][15:0]   pwm_free_count;
    logic [7:0]         pwm_count_clear, pwm_out_pin;
    int unsigned        miscompares, tests_run, cyc = 0;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [5:0]  RA [10] = '{6'h00, 6'h0C, 6'h12, 6'h14, 6'h18, 6'h20, 6'h28, 6'h16, 6'h30, 6'h31};
    localparam logic [15:0] RV [10] = '{16'hFFFF, 16'hFF, 16'hFFFF, 16'h0, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                                        16'h0, 16'h0, 16'h0};
    localparam logic [5:0]  WA [3] = '{6'h05, 6'h23, 6'h2B};

    tcc_regs i_dut (.clk_sys, .rst_n, .standby, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .cc_pin, .cc_pfs, .cc_free_count, .cc_cmp_out,
        .ch9_tally, .ch9_edge, .ch3_trigger_enable, .ch9_match, .ch11_free_count, .ch11_pfs, .ch11_cmp_out,
        .pulse_sequencer_trig, .chan0_capture_a, .osb_edge_sel, .ch1_free_count, .ch2_free_count,
        .pwm_free_count, .pwm_count_clear, .pwm_out_pin);
    tcc_far_side i_far (.clk_sys, .rst_n, .pwm_count_clear, .pwm_free_count, .cc_pin, .chan0_capture_a);

    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd

    // Pin stays high from the period restart through the duty match
    function automatic logic pwm_exp(input logic [15:0] cnt, input logic [15:0] duty);
        return cnt <= duty;
    endfunction : pwm_exp

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // Holds the request until waitrequest is sampled low at a rising edge; read data taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dt, input logic [3:0] be);
        @(posedge clk_sys);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= dt;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : bus

    task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
        bus(1'h0, a, 32'h0, 4'hF);
        chk(n, x, rd & m);
    endtask : rdc

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        {standby, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, ch3_trigger_enable} = '0;
        {cc_pfs, ch11_pfs, cc_free_count, ch9_tally, ch9_edge, osb_edge_sel} = '0;
        {ch11_free_count, ch1_free_count, ch2_free_count, miscompares, tests_run} = '0;
        rst_n = 1'h0;
        seed = 32'h7F2F;
        tick(5);
        rst_n <= 1'h1;
        for (int i = 0; i < 10; i++) rdc("reset", RA[i], {16'h0, RV[i]}, ALL);
        v = rnd();
        p = 16'h12C + {8'h0, v[7:0]};
        d = 16'h2 + (rnd() % (p - 16'h8));
        bus(1'h1, 6'h18, {16'h0, p}, 4'hF);
        bus(1'h1, 6'h20, {16'h0, d}, 4'hF);
        do @(negedge clk_sys); while (pwm_count_clear[0] !== 1'h1);
        repeat (p + 4) begin
            @(negedge clk_sys);
            c = pwm_free_count[0];
            if (c >= 1 && c <= p) chk("pwm pin", pwm_exp(c, d), pwm_out_pin[0]);
        end
        rdc("duty load", 6'h28, {16'h0, d}, ALL);
        rdc("period flag", 6'h30, 32'h100000, 32'h100000);
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            bus(1'h1, WA[i], {16'h0, v}, 4'hF);
            bus(1'h1, WA[i], {16'h0, ~v}, 4'h1);
            rdc("word only", WA[i], {16'h0, v}, ALL);
        end
        bus(1'h1, 6'h0D, {24'h0, v[7:0]}, 4'h1);
        rdc("byte access", 6'h0D, {24'h0, v[7:0]}, ALL);
        bus(1'h1, 6'h14, {16'h0, v}, 4'hF);
        rdc("read only", 6'h14, 32'h0, ALL);
        tick(1);
        cc_pfs[0] <= '{1'h1, 2'h1};
        c = rnd();
        cc_free_count[0] <= c;
        i_far.edge_pin(0, 1'h1);
        tick(6);
        rdc("capture", 6'h00, {16'h0, c}, ALL);
        rdc("capture flag", 6'h30, 32'h1, 32'h1);
        tick(1);
        cc_free_count[0] <= rnd();
        i_far.edge_pin(0, 1'h0);
        tick(6);
        rdc("edge select", 6'h00, {16'h0, c}, ALL);
        bus(1'h1, 6'h31, 32'h4001, 4'hF);
        @(negedge clk_sys);
        chk("irq set", 1'h1, irq);
        bus(1'h1, 6'h30, 32'h1, 4'hF);
        @(negedge clk_sys);
        chk("irq clear", 1'h0, irq);
        e = c;
        for (int en = 1; en >= 0; en--) begin
            bus(1'h1, 6'h30, 32'hFFFFFFF, 4'hF);
            v = rnd();
            bus(1'h1, 6'h0C, {24'h0, v[7:0]}, 4'h1);
            c = rnd();
            tick(1);
            ch9_tally[0] <= v[7:0];
            ch3_trigger_enable[0] <= en[0];
            cc_free_count[0] <= c;
            tick(3);
            ch9_edge[0] <= 1'h1;
            tick(1);
            ch9_edge[0] <= 1'h0;
            @(negedge clk_sys);
            chk("ch9 match", 1'h1, ch9_match[0]);
            if (en) e = c;
            rdc("ch9 trigger", 6'h00, {16'h0, e}, ALL);
            rdc("ch9 flags", 6'h30, 32'h4000, 32'h4001);
            chk("irq ch9", 1'h1, irq);
        end
        tick(1);
        cc_pfs[1] <= '{1'h0, 2'h2};
        ch11_pfs[0] <= '{1'h0, 2'h3};
        v = rnd();
        bus(1'h1, 6'h01, {16'h0, v}, 4'hF);
        bus(1'h1, 6'h12, {16'h0, v}, 4'hF);
        tick(1);
        cc_free_count[0] <= v;
        ch11_free_count <= v;
        e = 16'h0;
        repeat (4) begin
            @(negedge clk_sys);
            e += pulse_sequencer_trig[0];
        end
        chk("sequencer pulses", 16'h1, e);
        chk("compare out", 1'h1, cc_cmp_out[1]);
        chk("ch11 out", 1'h1, ch11_cmp_out[0]);
        rdc("compare flags", 6'h30, 32'h1002, 32'h1002);
        tick(1);
        osb_edge_sel <= 2'h1;
        v = rnd();
        c = rnd();
        ch1_free_count <= v;
        ch2_free_count <= c;
        i_far.edge_pin(12, 1'h1);
        tick(6);
        rdc("offset base 1", 6'h14, {16'h0, v}, ALL);
        rdc("offset base 2", 6'h15, {16'h0, c}, ALL);
        tick(1);
        standby <= 1'h1;
        tick(1);
        standby <= 1'h0;
        rdc("standby", 6'h18, 32'hFFFF, ALL);
        conclude();
    end
endmodule : tcc_regs_tb_top
`default_nettype wire
